//--- design/almh_lane_map_ctrl.sv
// Lane-map decode, aux routing and hot-plug gating of the alt-mode redriver
`timescale 1ns/100ps
module almh_lane_map_ctrl
    import almh_pkg::*;
#(
    parameter int HOLD_CYCLES = DEBOUNCE_CYCLES
)
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // Configuration pins
    input  wire logic [2:0] lane_map_code,
    input  wire logic       reg_ctrl_select,
    input  wire logic       sink_hotplug_in,
    // Register port
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    // Routing outputs
    output almh_route_type  route,
    output logic      [3:0] active_code,
    output logic            pair_one_enable,
    output logic            pair_two_enable,
    output logic            hotplug_level
);

    ////////////////////////////////////////////////////////////////////////
    // Elaboration checks

    // Hold time must span at least one low cycle
    if (HOLD_CYCLES < 1)
    begin : g_chk_hold
        $error("HOLD_CYCLES must be at least one");
    end

    // Counter width comes from HOLD_CYCLES + 1, which must not overflow
    if (HOLD_CYCLES > 32'h3FFF_FFFF)
    begin : g_chk_span
        $error("HOLD_CYCLES too large for the debounce counter");
    end

    // Lane-map field must sit wholly inside its byte
    if (LANE_MAP_FIELD_LSB < 0 || LANE_MAP_FIELD_LSB > 4)
    begin : g_chk_field
        $error("Lane-map field lies outside its register");
    end

    // Bypass bit must address a bit of its byte
    if (HOTPLUG_BYPASS_BIT < 0 || HOTPLUG_BYPASS_BIT > 7)
    begin : g_chk_bypass
        $error("Bypass bit lies outside its register");
    end

    // Polarity bit must address a bit of its byte
    if (HOTPLUG_POL_BIT < 0 || HOTPLUG_POL_BIT > 7)
    begin : g_chk_pol
        $error("Polarity bit lies outside its register");
    end

    // Shared offsets would let one write land in two registers
    if (LANE_MAP_CONFIG_OFF == HOTPLUG_GATE_CONFIG_OFF ||
        LANE_MAP_CONFIG_OFF == HOTPLUG_POL_CONFIG_OFF  ||
        HOTPLUG_GATE_CONFIG_OFF == HOTPLUG_POL_CONFIG_OFF)
    begin : g_chk_offsets
        $error("Register offsets must be distinct");
    end

    // A zero debounce default would leave the filter transparent
    if (DEBOUNCE_CYCLES < 1)
    begin : g_chk_default
        $error("Debounce default must be at least one cycle");
    end

    ////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed
    {
        logic [7:0]     lane_map_config;
        logic [7:0]     hotplug_gate_config;
        logic [7:0]     hotplug_pol_config;
        logic [2:0]     pins_meta;
        logic [2:0]     pins_sync;
        logic [1:0]     sel_meta;
        logic           hp_meta;
        logic           hp_sync;
        logic [7:0]     rdata;
        almh_route_type route;
        logic [3:0]     code;
        logic           en_one;
        logic           en_two;
    } almh_state_type;

    // Registered copy and its next value
    almh_state_type state_r;
    almh_state_type state_nxt;

    logic           sel_sync;
    logic           hp_active;
    logic           hp_filtered;
    logic [3:0]     code_sel;
    almh_route_type route_dec;
    logic           gate;

    assign sel_sync = state_r.sel_meta[1];

    ////////////////////////////////////////////////////////////////////////
    // Hot-plug polarity and debounce

    // Polarity applied after the synchroniser so the filter sees asserted level
    assign hp_active = state_r.hp_sync ^ state_r.hotplug_pol_config[HOTPLUG_POL_BIT];

    // One filter serves both polarities since it sees the asserted level
    almh_debounce #(
        .HOLD_CYCLES (HOLD_CYCLES)
    ) u_debounce (
        .clk       (clk),
        .rst_b     (rst_b),
        .level_in  (hp_active),
        .level_out (hp_filtered)
    );

    ////////////////////////////////////////////////////////////////////////
    // Code source and decode

    // Pin mode zero-extends three pins, so the upper codes stay unreachable
    always_comb
    begin
        if (sel_sync)
            code_sel = state_r.lane_map_config[LANE_MAP_FIELD_LSB +: 4];
        else
            code_sel = {1'b0, state_r.pins_sync};
    end

    // Lane-map table; the all-display flip codes touch only the aux crossing
    always_comb
    begin
        route_dec = '0;
        unique case (code_sel)
            4'b0000, 4'b0001:
                route_dec = '0;
            4'b0010, 4'b0011:
            begin
                route_dec.pair_one_src   = SRC_CH1;
                route_dec.pair_two_src   = SRC_CH2;
                route_dec.pair_one_proto = PROTO_DISP;
                route_dec.pair_two_proto = PROTO_DISP;
                route_dec.aux_used       = 1'b1;
                route_dec.aux_crossed    = code_sel[0];
                route_dec.hp_pair_one    = 1'b1;
                route_dec.hp_pair_two    = 1'b1;
            end
            4'b0100:
            begin
                route_dec.pair_one_src   = SRC_CH1;
                route_dec.pair_one_proto = PROTO_USB;
            end
            4'b0101:
            begin
                route_dec.pair_two_src   = SRC_CH2;
                route_dec.pair_two_proto = PROTO_USB;
            end
            4'b0110:
            begin
                route_dec.pair_one_src   = SRC_CH1;
                route_dec.pair_two_src   = SRC_CH2;
                route_dec.pair_one_proto = PROTO_USB;
                route_dec.pair_two_proto = PROTO_DISP;
                route_dec.aux_used       = 1'b1;
                route_dec.hp_pair_two    = 1'b1;
            end
            4'b0111:
            begin
                route_dec.pair_one_src   = SRC_CH1;
                route_dec.pair_two_src   = SRC_CH2;
                route_dec.pair_one_proto = PROTO_DISP;
                route_dec.pair_two_proto = PROTO_USB;
                route_dec.aux_used       = 1'b1;
                route_dec.aux_crossed    = 1'b1;
                route_dec.hp_pair_one    = 1'b1;
            end
            4'b1000:
            begin
                route_dec.pair_one_src   = SRC_CH1;
                route_dec.pair_two_src   = SRC_CH2;
                route_dec.pair_one_proto = PROTO_DISP;
                route_dec.pair_two_proto = PROTO_USB;
                route_dec.aux_used       = 1'b1;
                route_dec.hp_pair_one    = 1'b1;
            end
            4'b1001:
            begin
                route_dec.pair_one_src   = SRC_CH1;
                route_dec.pair_two_src   = SRC_CH2;
                route_dec.pair_one_proto = PROTO_USB;
                route_dec.pair_two_proto = PROTO_DISP;
                route_dec.aux_used       = 1'b1;
                route_dec.aux_crossed    = 1'b1;
                route_dec.hp_pair_two    = 1'b1;
            end
            4'b1010, 4'b1011:
            begin
                route_dec.pair_one_src   = SRC_CH1;
                route_dec.pair_two_src   = SRC_CH2;
                route_dec.pair_one_proto = PROTO_DISP;
                route_dec.pair_two_proto = PROTO_DISP;
                route_dec.aux_used       = 1'b1;
                route_dec.aux_crossed    = code_sel[0];
                route_dec.hp_pair_one    = 1'b1;
                route_dec.hp_pair_two    = 1'b1;
                route_dec.hp_pin_only    = 1'b1;
            end
            4'b1100:
            begin
                route_dec.pair_one_src   = SRC_CH1;
                route_dec.pair_two_src   = SRC_CH2;
                route_dec.pair_one_proto = PROTO_USB;
                route_dec.pair_two_proto = PROTO_USB;
            end
            4'b1101:
            begin
                route_dec.pair_one_src   = SRC_CH1;
                route_dec.pair_two_src   = SRC_CH2;
                route_dec.pair_one_proto = PROTO_PCIE;
                route_dec.pair_two_proto = PROTO_PCIE;
            end
            4'b1110:
            begin
                route_dec.pair_one_src   = SRC_CH1;
                route_dec.pair_two_src   = SRC_CH2;
                route_dec.pair_one_proto = PROTO_USB;
                route_dec.pair_two_proto = PROTO_PCIE;
            end
            4'b1111:
            begin
                route_dec.pair_one_src   = SRC_CH1;
                route_dec.pair_two_src   = SRC_CH2;
                route_dec.pair_one_proto = PROTO_PCIE;
                route_dec.pair_two_proto = PROTO_USB;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state

    // Bypass holds display lanes on whatever the pin says
    assign gate = state_r.hotplug_gate_config[HOTPLUG_BYPASS_BIT] | hp_filtered;

    always_comb
    begin
        state_nxt = state_r;

        // Two-stage synchronisers on every pin
        state_nxt.pins_meta = lane_map_code;
        state_nxt.pins_sync = state_r.pins_meta;
        state_nxt.sel_meta  = {state_r.sel_meta[0], reg_ctrl_select};
        state_nxt.hp_meta   = sink_hotplug_in;
        state_nxt.hp_sync   = state_r.hp_meta;

        // Register writes; register mode never reads the lane-map pins
        if (reg_wr)
        begin
            unique case (reg_addr)
                LANE_MAP_CONFIG_OFF:     state_nxt.lane_map_config = reg_wdata;
                HOTPLUG_GATE_CONFIG_OFF: state_nxt.hotplug_gate_config = reg_wdata;
                HOTPLUG_POL_CONFIG_OFF:  state_nxt.hotplug_pol_config = reg_wdata;
                default:                 ;
            endcase
        end

        // Register reads, unmapped addresses read zero
        if (reg_rd)
        begin
            unique case (reg_addr)
                LANE_MAP_CONFIG_OFF:     state_nxt.rdata = state_r.lane_map_config;
                HOTPLUG_GATE_CONFIG_OFF: state_nxt.rdata = state_r.hotplug_gate_config;
                HOTPLUG_POL_CONFIG_OFF:  state_nxt.rdata = state_r.hotplug_pol_config;
                default:                 state_nxt.rdata = 8'h00;
            endcase
        end

        // Registered routing; hot-plug only matters on responding pairs
        state_nxt.route  = route_dec;
        state_nxt.code   = code_sel;
        state_nxt.en_one = (route_dec.pair_one_proto != PROTO_NONE) &&
                           (!route_dec.hp_pair_one || gate);
        state_nxt.en_two = (route_dec.pair_two_proto != PROTO_NONE) &&
                           (!route_dec.hp_pair_two || gate);
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    // Synchronous reset; select comes up in register mode
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            state_r                     <= '0;
            state_r.lane_map_config     <= LANE_MAP_CONFIG_RST;
            state_r.hotplug_gate_config <= HOTPLUG_GATE_CONFIG_RST;
            state_r.hotplug_pol_config  <= HOTPLUG_POL_CONFIG_RST;
            state_r.sel_meta            <= 2'b11; // Register mode is the default
        end
        else
            state_r <= state_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign reg_rdata       = state_r.rdata;
    assign route           = state_r.route;
    assign active_code     = state_r.code;
    assign pair_one_enable = state_r.en_one;
    assign pair_two_enable = state_r.en_two;
    assign hotplug_level   = hp_filtered;

endmodule // almh_lane_map_ctrl

//--- design/almh_pkg.sv
// Package for the alt-mode lane map and hot-plug control block
package almh_pkg;

    // Register byte offsets
    localparam logic [7:0] LANE_MAP_CONFIG_OFF     = 8'h03;
    localparam logic [7:0] HOTPLUG_GATE_CONFIG_OFF = 8'h12;
    localparam logic [7:0] HOTPLUG_POL_CONFIG_OFF  = 8'h04;

    // Field positions
    localparam int LANE_MAP_FIELD_LSB   = 4;
    localparam int HOTPLUG_BYPASS_BIT   = 2;
    localparam int HOTPLUG_POL_BIT      = 1;

    // Reset values
    localparam logic [7:0] LANE_MAP_CONFIG_RST     = 8'h00;
    localparam logic [7:0] HOTPLUG_GATE_CONFIG_RST = 8'h00;
    localparam logic [7:0] HOTPLUG_POL_CONFIG_RST  = 8'h00;

    // Timing
    localparam int CLK_HZ           = 20_000_000;
    localparam int DEBOUNCE_MS      = 325;
    localparam int DEBOUNCE_CYCLES  = (CLK_HZ / 1000) * DEBOUNCE_MS;

    // Source of each connector pair
    typedef enum logic [1:0]
    {
        SRC_NONE = 2'b00,
        SRC_CH1  = 2'b01,
        SRC_CH2  = 2'b10
    } almh_src_type;

    // Protocol carried by a connector pair
    typedef enum logic [1:0]
    {
        PROTO_NONE = 2'b00,
        PROTO_USB  = 2'b01,
        PROTO_DISP = 2'b10,
        PROTO_PCIE = 2'b11
    } almh_proto_type;

    // Decoded routing for one lane-map code
    typedef struct packed
    {
        almh_src_type   pair_one_src;
        almh_src_type   pair_two_src;
        almh_proto_type pair_one_proto;
        almh_proto_type pair_two_proto;
        logic           aux_used;
        logic           aux_crossed;
        logic           hp_pair_one;
        logic           hp_pair_two;
        logic           hp_pin_only;
    } almh_route_type;

endpackage

//--- design/almh_debounce.sv
// Hot-plug de-assert debounce: rise passes at once, fall after a hold time
`timescale 1ns/100ps
module almh_debounce
    import almh_pkg::*;
#(
    parameter int HOLD_CYCLES = DEBOUNCE_CYCLES
)
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // Synchronised level in, filtered level out
    input  wire logic level_in,
    output logic      level_out
);

    localparam int CW = $clog2(HOLD_CYCLES + 1);

    // Hold time must span at least one low cycle
    if (HOLD_CYCLES < 1)
    begin : g_chk_hold
        $error("HOLD_CYCLES must be at least one");
    end

    typedef struct packed
    {
        logic [CW-1:0] cnt;
        logic          level;
    } almh_deb_state_type;

    almh_deb_state_type state_r;
    almh_deb_state_type state_nxt;

    // Counter only runs while input sits low and output is still high
    always_comb
    begin
        state_nxt = state_r;
        if (level_in)
        begin
            state_nxt.level = 1'b1;
            state_nxt.cnt   = '0;
        end
        else if (state_r.level)
        begin
            if (state_r.cnt == CW'(HOLD_CYCLES - 1))
            begin
                state_nxt.level = 1'b0;
                state_nxt.cnt   = '0;
            end
            else
                state_nxt.cnt = state_r.cnt + 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            state_r <= '0;
        else
            state_r <= state_nxt;
    end

    assign level_out = state_r.level;

endmodule // almh_debounce

//--- test/almh_chk_properties.sv
// Checker of lane-map, register and hot-plug behaviour at the block ports
`timescale 1ns/100ps
module almh_chk
    import almh_pkg::*;
#(
    parameter int HOLD_CYCLES = 20
)
(
    // Clock and reset
    input wire logic           clk,
    input wire logic           rst_b,
    // Pins
    input wire logic     [2:0] lane_map_code,
    input wire logic           reg_ctrl_select,
    input wire logic           sink_hotplug_in,
    // Register port
    input wire logic           reg_wr,
    input wire logic           reg_rd,
    input wire logic     [7:0] reg_addr,
    input wire logic     [7:0] reg_wdata,
    input wire logic     [7:0] reg_rdata,
    // Outputs
    input wire almh_route_type route,
    input wire logic     [3:0] active_code,
    input wire logic           pair_one_enable,
    input wire logic           pair_two_enable,
    input wire logic           hotplug_level
);
    logic pol_r;
    logic byp_r;
    int   low_cnt_r;
    logic hp_in;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // Asserted hot-plug level as the design should see it
    assign hp_in = sink_hotplug_in ^ pol_r;

    // Shadow bits and low-run counter; saturates so it never wraps
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            pol_r     <= 1'b0;
            byp_r     <= 1'b0;
            low_cnt_r <= 0;
        end
        else
        begin
            if (reg_wr && reg_addr == HOTPLUG_POL_CONFIG_OFF)
                pol_r <= reg_wdata[HOTPLUG_POL_BIT];
            if (reg_wr && reg_addr == HOTPLUG_GATE_CONFIG_OFF)
                byp_r <= reg_wdata[HOTPLUG_BYPASS_BIT];
            if (hp_in)
                low_cnt_r <= 0;
            else if (low_cnt_r < HOLD_CYCLES + 8)
                low_cnt_r <= low_cnt_r + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sequences and properties
    sequence s_lane_wr;
        reg_wr && reg_addr == LANE_MAP_CONFIG_OFF;
    endsequence
    sequence s_lane_rd;
        reg_rd && reg_addr == LANE_MAP_CONFIG_OFF;
    endsequence
    sequence s_gate_steady;
        ($stable(route) && $stable(byp_r) && $stable(hotplug_level) && route.hp_pair_two
            && route.pair_two_proto != PROTO_NONE)[*2];
    endsequence

    property p_readback;
        s_lane_wr ##1 s_lane_rd |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    property p_unmapped;
        reg_rd && !(reg_addr inside {8'h03, 8'h04, 8'h12}) |=> reg_rdata == 8'h00;
    endproperty
    property p_reg_code;
        reg_ctrl_select[*4] ##0 s_lane_wr ##1 (reg_ctrl_select && !reg_wr)
            |=> active_code == $past(reg_wdata[7:4], 2);
    endproperty
    property p_pin_code;
        (!reg_ctrl_select && $stable(lane_map_code))[*6] |-> active_code == {1'b0, lane_map_code};
    endproperty
    property p_pins_ignored;
        (reg_ctrl_select && !reg_wr)[*6] |=> $stable(active_code);
    endproperty
    property p_hp_rise;
        (hp_in && $stable(pol_r))[*5] |-> hotplug_level;
    endproperty
    property p_fall_early;
        $fell(hotplug_level) |-> low_cnt_r >= HOLD_CYCLES;
    endproperty
    property p_fall_due;
        low_cnt_r == HOLD_CYCLES + 6 |-> !hotplug_level;
    endproperty
    property p_gate;
        s_gate_steady |-> pair_two_enable == (hotplug_level || byp_r);
    endproperty
    property p_idle_pair;
        (route.pair_one_proto == PROTO_NONE)[*2] |-> !pair_one_enable;
    endproperty

    a_readback:     assert property (p_readback) else $error("lane map readback wrong");
    a_unmapped:     assert property (p_unmapped) else $error("unmapped read not zero");
    a_reg_code:     assert property (p_reg_code) else $error("register code not applied");
    a_pin_code:     assert property (p_pin_code) else $error("pin code not applied");
    a_pins_ignored: assert property (p_pins_ignored) else $error("code moved in reg mode");
    a_hp_rise:      assert property (p_hp_rise) else $error("hot-plug rise late");
    a_fall_early:   assert property (p_fall_early) else $error("hot-plug fell early");
    a_fall_due:     assert property (p_fall_due) else $error("hot-plug fall late");
    a_gate:         assert property (p_gate) else $error("pair two gate wrong");
    a_idle_pair:    assert property (p_idle_pair) else $error("idle pair enabled");
endmodule // almh_chk

bind almh_lane_map_ctrl almh_chk #(.HOLD_CYCLES(HOLD_CYCLES)) i_almh_chk
(
    .clk(clk), .rst_b(rst_b), .lane_map_code(lane_map_code),
    .reg_ctrl_select(reg_ctrl_select), .sink_hotplug_in(sink_hotplug_in),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .route(route), .active_code(active_code),
    .pair_one_enable(pair_one_enable), .pair_two_enable(pair_two_enable),
    .hotplug_level(hotplug_level)
);

//--- test/almh_sink_model.sv
// Behavioural display sink driving the hot-plug line
`timescale 1ns/100ps
module almh_sink_model
(
    // Sink state from the bench
    input  wire logic plugged,
    input  wire logic glitch,
    input  wire logic active_low,
    // Hot-plug line toward the redriver
    output logic      hotplug_out
);
    // A short glitch models a replug bounce during unplug
    assign hotplug_out = (plugged | glitch) ^ active_low;
endmodule // almh_sink_model

//--- test/tb_top.sv
// Self-checking bench for the lane-map and hot-plug control block
`timescale 1ns/100ps
module tb_top
    import almh_pkg::*;
;
    localparam int HOLD = 20;
    localparam logic [12:0] EXP_ROUTE [16] = '{
        13'h0000, 13'h0000, 13'h0d56, 13'h0d5e, 13'h0880, 13'h0420, 13'h0cd2, 13'h0d3c,
        13'h0d34, 13'h0cda, 13'h0d57, 13'h0d5f, 13'h0ca0, 13'h0de0, 13'h0ce0, 13'h0da0};
    logic           clk;
    logic           rst_b;
    logic     [2:0] lane_map_code;
    logic           reg_ctrl_select;
    logic           hp_pin;
    logic           reg_wr;
    logic           reg_rd;
    logic     [7:0] reg_addr;
    logic     [7:0] reg_wdata;
    logic     [7:0] reg_rdata;
    almh_route_type route;
    logic     [3:0] active_code;
    logic           pair_one_enable;
    logic           pair_two_enable;
    logic           hotplug_level;
    logic           plugged;
    logic           glitch;
    logic           act_low;
    int             failures;
    int             checks;
    int             n;

    ////////////////////////////////////////////////////////////////////////////////
    // Design, sink and clock; short hold keeps the run brief
    almh_lane_map_ctrl #(.HOLD_CYCLES(HOLD)) i_almh_lane_map_ctrl
    (
        .clk(clk), .rst_b(rst_b), .lane_map_code(lane_map_code),
        .reg_ctrl_select(reg_ctrl_select), .sink_hotplug_in(hp_pin),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .route(route), .active_code(active_code),
        .pair_one_enable(pair_one_enable), .pair_two_enable(pair_two_enable),
        .hotplug_level(hotplug_level)
    );
    almh_sink_model i_almh_sink_model
    (
        .plugged(plugged), .glitch(glitch), .active_low(act_low), .hotplug_out(hp_pin)
    );
    always #25 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    // Tasks; every drive lands 2 ns after a rising edge
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #2;
    endtask
    task automatic fail_msg(input logic [12:0] got, input logic [12:0] exp);
        failures++;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
            fail_msg({5'h00, got}, {5'h00, exp});
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp)
            fail_msg({12'h000, got}, {12'h000, exp});
    endtask
    task automatic chk_route(input almh_route_type got, input logic [12:0] exp,
                             input logic [12:0] mask);
        checks++;
        if ((got & mask) !== (exp & mask))
            fail_msg(got, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr    = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        cyc(1);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_rd   = 1'b1;
        reg_addr = a;
        cyc(1);
        reg_rd = 1'b0;
        cyc(1);
        chk_byte(reg_rdata, e);
    endtask
    task automatic test_done();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog well past the expected run of under two hundred cycles
    initial
    begin
        cyc(3000);
        failures++;
        $display("[ERR] %0t watchdog expired", $time);
        test_done();
    end

    // Main sequence
    initial
    begin
        {clk, rst_b, reg_wr, reg_rd, plugged, glitch, act_low} = 7'h00;
        failures = 0;
        checks = 0;
        n = 0;
        {lane_map_code, reg_addr, reg_wdata} = 19'h0_0000;
        reg_ctrl_select = 1'b1;
        cyc(10);
        rst_b = 1'b1;
        rd(LANE_MAP_CONFIG_OFF, 8'h00);
        rd(HOTPLUG_GATE_CONFIG_OFF, 8'h00);
        rd(HOTPLUG_POL_CONFIG_OFF, 8'h00);
        rd(8'h55, 8'h00);
        // Every code written then read straight back
        for (int c = 0; c < 16; c++)
        begin
            wr(LANE_MAP_CONFIG_OFF, {c[3:0], 4'h0});
            rd(LANE_MAP_CONFIG_OFF, {c[3:0], 4'h0});
            chk_byte({4'h0, active_code}, {4'h0, c[3:0]});
            chk_route(route, EXP_ROUTE[c], 13'h1fff);
        end
        // Gate on pair two only, bypass then pin
        wr(LANE_MAP_CONFIG_OFF, 8'h60);
        cyc(4);
        chk_bit(pair_one_enable, 1'b1);
        chk_bit(pair_two_enable, 1'b0);
        wr(HOTPLUG_GATE_CONFIG_OFF, 8'h04);
        cyc(2);
        chk_bit(pair_two_enable, 1'b1);
        wr(HOTPLUG_GATE_CONFIG_OFF, 8'h00);
        cyc(2);
        chk_bit(pair_two_enable, 1'b0);
        plugged = 1'b1;
        cyc(3);
        chk_bit(hotplug_level, 1'b1);
        cyc(1);
        chk_bit(pair_two_enable, 1'b1);
        // Unplug with a bounce part way through the hold
        plugged = 1'b0;
        cyc(HOLD - 4);
        chk_bit(hotplug_level, 1'b1);
        glitch = 1'b1;
        cyc(2);
        glitch = 1'b0;
        cyc(HOLD - 2);
        chk_bit(hotplug_level, 1'b1);
        while (hotplug_level === 1'b1 && n < 10)
        begin
            cyc(1);
            n++;
        end
        chk_bit(hotplug_level, 1'b0);
        // Active-low sink with the polarity bit set
        wr(HOTPLUG_POL_CONFIG_OFF, 8'h02);
        act_low = 1'b1;
        plugged = 1'b1;
        cyc(5);
        chk_bit(hotplug_level, 1'b1);
        plugged = 1'b0;
        cyc(HOLD + 12);
        chk_bit(hotplug_level, 1'b0);
        act_low = 1'b0;
        wr(HOTPLUG_POL_CONFIG_OFF, 8'h00);
        // Pin mode against register mode
        lane_map_code = 3'b111;
        wr(LANE_MAP_CONFIG_OFF, 8'h20);
        cyc(4);
        chk_byte({4'h0, active_code}, 8'h02);
        reg_ctrl_select = 1'b0;
        cyc(4);
        chk_byte({4'h0, active_code}, 8'h07);
        wr(LANE_MAP_CONFIG_OFF, 8'h90);
        cyc(3);
        chk_byte({4'h0, active_code}, 8'h07);
        reg_ctrl_select = 1'b1;
        cyc(4);
        chk_byte({4'h0, active_code}, 8'h09);
        // Second reset in mid-run
        rst_b = 1'b0;
        cyc(3);
        rst_b = 1'b1;
        rd(LANE_MAP_CONFIG_OFF, 8'h00);
        test_done();
    end
endmodule // tb_top
